//--- pfsm_pkg.sv
package pfsm_pkg;
  // pin function sources, lowest priority first
  localparam int PFSM_NSRC = 5;
  localparam logic [2:0] PFSM_SRC_PORT = 3'h0;
  localparam logic [2:0] PFSM_SRC_ALT1 = 3'h1;
  localparam logic [2:0] PFSM_SRC_ALT4 = 3'h4;
  // pins in the default configuration
  localparam int PFSM_NPIN = 8;
  // shared debug pin sits on pin index 4, sda on 2, scl on 3
  localparam int PFSM_DBG_PIN = 4;
  localparam int PFSM_SDA_PIN = 2;
  localparam int PFSM_SCL_PIN = 3;
  // register map on the plain register port
  localparam logic [3:0] PFSM_A_OPT = 4'h0;   // system_options_one
  localparam logic [3:0] PFSM_A_DAT = 4'h1;   // port data
  localparam logic [3:0] PFSM_A_DIR = 4'h2;   // port direction, 1 = output
  localparam logic [3:0] PFSM_A_PUE = 4'h3;   // pull-up enables
  localparam logic [3:0] PFSM_A_HDR = 4'h4;   // high drive select
  localparam logic [3:0] PFSM_A_IN = 4'h5;    // pin levels, read only
  // system_options_one fields
  localparam int PFSM_OPT_DBGEN = 0;          // debug_pin_enable
  localparam int PFSM_OPT_BGMODE = 1;         // active background mode, read only
  localparam int PFSM_OPT_IICPIN = 2;         // sda/scl serve the i2c function
  localparam logic [7:0] PFSM_OPT_RST = 8'h01;
  localparam logic [7:0] PFSM_ZERO8 = 8'h00;
  // debug bit time in debug clocks
  localparam int PFSM_DBG_BIT_CLKS = 16;
  // high-current pins as a mask
  localparam logic [7:0] PFSM_HICUR_MASK = 8'h30;
endpackage

//--- pfsm_prio.sv
`timescale 1ns/1ps
// picks the highest-priority enabled function for one pin
module pfsm_prio
  import pfsm_pkg::*;
(
  input wire logic [pfsm_pkg::PFSM_NSRC-1:0] i_en,
  input wire logic [pfsm_pkg::PFSM_NSRC-1:0] i_out,
  input wire logic [pfsm_pkg::PFSM_NSRC-1:0] i_drv,
  output logic o_out,
  output logic o_drv,
  output logic o_per_in
);
  // higher index wins; port function (index 0) is always enabled
  always_comb
  begin
    o_out = i_out[0];
    o_drv = i_drv[0];
    o_per_in = 1'b0;
    for (int k = 1; k < PFSM_NSRC; k++)
    begin
      if (i_en[k])
      begin
        o_out = i_out[k];
        o_drv = i_drv[k];
        o_per_in = !i_drv[k];
      end
    end
  end
endmodule

//--- pfsm_top.sv
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// How it works
// - in reset, debug pin is mode input only
// - debug role: pull-up plus normal driver enabled
// - debug_pin_enable set by reset, cleared by software
// - sample mode pin at reset release
// - debug bit lasts sixteen debug clocks
// - releasing side drives brief high speedup pulse
// - input pull-ups per bit, off when output
// - sda/scl true open drain, pull-up kept in i2c mode
// - sda/scl pull-up off while driving low
// - debug pin as port bit: output only
// - pull-up allowed for peripheral inputs too
// - high drive selectable on driven high-current outputs
// - after reset all pins hi-z, no pull-up except the debug pin
// - highest enabled function owns the pin
// - any internal reset drives reset pin low
module pfsm_top
  import pfsm_pkg::*;
#(
  parameter int NPIN = pfsm_pkg::PFSM_NPIN
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst,                      // internal reset, any source
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic [NPIN-1:0] i_pin,           // pad levels
  input wire logic [NPIN*4-1:0] i_alt_en,      // alt1..alt4 enable per pin
  input wire logic [NPIN*4-1:0] i_alt_out,
  input wire logic [NPIN*4-1:0] i_alt_drv,     // alt drives the pin as output
  input wire logic i_dbg_tx_en,                // debug controller drives low bit
  input wire logic i_dbg_speedup,              // debug controller high pulse
  output logic [NPIN-1:0] o_pin_out,
  output logic [NPIN-1:0] o_pin_oe_n,          // low while driving
  output logic [NPIN-1:0] o_pin_pu,
  output logic [NPIN-1:0] o_pin_hidrv,
  output logic [NPIN-1:0] o_per_in,            // to peripherals
  output logic o_dbg_rx,                       // debug line level to controller
  output logic o_bg_mode,                      // active background mode
  output logic o_rst_pin_out,
  output logic o_rst_pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [7:0] opt_r;        // system_options_one
    logic [7:0] dat_r;
    logic [7:0] dir_r;
    logic [7:0] pue_r;
    logic [7:0] hdr_r;
    logic [7:0] rdata_r;
    logic in_rst_r;           // reset was active last cycle
    logic [NPIN-1:0] out_r;
    logic [NPIN-1:0] oe_n_r;
    logic [NPIN-1:0] pu_r;
    logic [NPIN-1:0] hd_r;
    logic [NPIN-1:0] pin_in_r;
    logic dbg_rx_r;
    logic rst_out_n_r;
    logic [NPIN-1:0] per_in_r;  // pin level handed to peripheral inputs
  } pfsm_st_t;

  pfsm_st_t st_r;
  pfsm_st_t st_nxt;

  // per-pin mux results
  logic [NPIN-1:0] mx_out;
  logic [NPIN-1:0] mx_drv;
  logic [NPIN-1:0] mx_pin_in;

  ////////////////////////////////////////////////////////////////////////
  // priority mux per pin, port function at the bottom
  genvar g;
  generate
    for (g = 0; g < NPIN; g++)
    begin : g_pin
      pfsm_prio u_prio
      (
        .i_en({i_alt_en[g*4 +: 4], 1'b1}),
        .i_out({i_alt_out[g*4 +: 4], st_r.dat_r[g]}),
        .i_drv({i_alt_drv[g*4 +: 4], st_r.dir_r[g]}),
        .o_out(mx_out[g]),
        .o_drv(mx_drv[g]),
        .o_per_in(mx_pin_in[g])
      );
    end
  endgenerate

  // register read decode, used for read data
  function automatic logic [7:0] rd_mux(input pfsm_st_t s, input logic [3:0] a,
                                        input logic [7:0] pins);
    case (a)
      PFSM_A_OPT: rd_mux = s.opt_r;
      PFSM_A_DAT: rd_mux = s.dat_r;
      PFSM_A_DIR: rd_mux = s.dir_r;
      PFSM_A_PUE: rd_mux = s.pue_r;
      PFSM_A_HDR: rd_mux = s.hdr_r;
      PFSM_A_IN: rd_mux = pins;
      default: rd_mux = PFSM_ZERO8;          // unmapped reads zero
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic port_in;
    logic iic_pin;
    logic [7:0] pins8;
    port_in = 1'b0;
    iic_pin = 1'b0;
    pins8 = PFSM_ZERO8;
    st_nxt = st_r;
    st_nxt.in_rst_r = i_rst;
    st_nxt.rdata_r = PFSM_ZERO8;
    for (int k = 0; k < NPIN && k < 8; k++)
      pins8[k] = st_r.pin_in_r[k];

    if (i_rst)
    begin
      // every reset sets the debug enable and clears port setup
      st_nxt.opt_r = PFSM_OPT_RST;
      st_nxt.dat_r = PFSM_ZERO8;
      st_nxt.dir_r = PFSM_ZERO8;
      st_nxt.pue_r = PFSM_ZERO8;
      st_nxt.hdr_r = PFSM_ZERO8;
      st_nxt.out_r = '0;
      st_nxt.oe_n_r = '1;                    // hi-z, no pull-up
      st_nxt.pu_r = '0;
      st_nxt.hd_r = '0;
      st_nxt.rst_out_n_r = 1'b0;             // drive reset pin low
      // debug pin is only a mode input now: pulled up, not driven
      st_nxt.pu_r[PFSM_DBG_PIN] = 1'b1;
    end
    else
    begin
      st_nxt.rst_out_n_r = 1'b1;
      // sample mode pin once, on the release edge of reset
      if (st_r.in_rst_r)
        st_nxt.opt_r[PFSM_OPT_BGMODE] = !i_pin[PFSM_DBG_PIN];
      // register writes; background mode bit is read only
      if (i_wr)
      begin
        case (i_addr)
          PFSM_A_OPT:
          begin
            st_nxt.opt_r[PFSM_OPT_DBGEN] = i_wdata[PFSM_OPT_DBGEN];
            st_nxt.opt_r[PFSM_OPT_IICPIN] = i_wdata[PFSM_OPT_IICPIN];
          end
          PFSM_A_DAT: st_nxt.dat_r = i_wdata;
          PFSM_A_DIR: st_nxt.dir_r = i_wdata;
          PFSM_A_PUE: st_nxt.pue_r = i_wdata;
          PFSM_A_HDR: st_nxt.hdr_r = i_wdata;
          default: st_nxt.rdata_r = st_nxt.rdata_r; // unmapped write ignored
        endcase
      end
      if (i_rd)
        st_nxt.rdata_r = rd_mux(st_r, i_addr, pins8);

      // pad controls from the mux, registered
      for (int k = 0; k < NPIN; k++)
      begin
        port_in = !mx_drv[k];
        iic_pin = st_r.opt_r[PFSM_OPT_IICPIN] &&
                  (k == PFSM_SDA_PIN || k == PFSM_SCL_PIN);
        st_nxt.out_r[k] = mx_out[k];
        st_nxt.oe_n_r[k] = !mx_drv[k];
        // pull-up only while input, per bit
        st_nxt.pu_r[k] = k < 8 ? st_r.pue_r[k % 8] && port_in : 1'b0;
        // high drive only on driven high-current pins
        st_nxt.hd_r[k] = k < 8 ? st_r.hdr_r[k % 8] && PFSM_HICUR_MASK[k % 8] &&
                         mx_drv[k] : 1'b0;
        if (k == PFSM_SDA_PIN || k == PFSM_SCL_PIN)
        begin
          // true open drain: drive only the low level
          st_nxt.out_r[k] = 1'b0;
          st_nxt.oe_n_r[k] = !(mx_drv[k] && !mx_out[k]);
          // i2c keeps pull-up as output, off while low
          if (iic_pin && mx_drv[k])
            st_nxt.pu_r[k] = st_r.pue_r[k] && mx_out[k];
        end
        if (k == PFSM_DBG_PIN)
        begin
          if (st_r.opt_r[PFSM_OPT_DBGEN])
          begin
            // debug role: pseudo open drain, high speedup pulse
            // bit timing of sixteen debug clocks lives in the controller
            st_nxt.pu_r[k] = 1'b1;
            st_nxt.out_r[k] = i_dbg_speedup;
            st_nxt.oe_n_r[k] = !(i_dbg_tx_en || i_dbg_speedup);
            st_nxt.hd_r[k] = 1'b0;
          end
          else
          begin
            // port role is output only, no pull-up
            st_nxt.pu_r[k] = 1'b0;
            st_nxt.oe_n_r[k] = !mx_drv[k];
          end
        end
      end
    end
    st_nxt.pin_in_r = i_pin;
    // gate with the next enable so the output is a plain flop
    st_nxt.dbg_rx_r = i_pin[PFSM_DBG_PIN] && st_nxt.opt_r[PFSM_OPT_DBGEN];
    // peripheral input, debug pin gives no input path as port
    st_nxt.per_in_r = mx_pin_in & i_pin;
    st_nxt.per_in_r[PFSM_DBG_PIN] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_ref_clk)
  begin
    st_r <= st_nxt;
  end

  // outputs straight from flops, reset pin level tied low
  assign o_rdata = st_r.rdata_r;
  assign o_pin_out = st_r.out_r;
  assign o_pin_oe_n = st_r.oe_n_r;
  assign o_pin_pu = st_r.pu_r;
  assign o_pin_hidrv = st_r.hd_r;
  assign o_dbg_rx = st_r.dbg_rx_r;
  assign o_per_in = st_r.per_in_r;
  assign o_bg_mode = st_r.opt_r[PFSM_OPT_BGMODE];
  assign o_rst_pin_out = 1'b0;
  assign o_rst_pin_oe_n = st_r.rst_out_n_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  rst_pin_a: assert property (@(posedge i_ref_clk) i_rst |=> !o_rst_pin_oe_n)
    else $error("reset pin not driven during reset");
  dbg_set_a: assert property (@(posedge i_ref_clk) i_rst |=> o_pin_pu[PFSM_DBG_PIN] &&
    o_pin_oe_n[PFSM_DBG_PIN])
    else $error("debug pin not a pulled-up input in reset");
  dbg_en_a: assert property (@(posedge i_ref_clk) $fell(i_rst) |-> st_r.opt_r[0])
    else $error("debug enable not set after reset");
  mode_smp_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $fell(st_r.in_rst_r) |-> o_bg_mode == !$past(i_pin[PFSM_DBG_PIN]))
    else $error("mode pin not sampled at release");
  pu_out_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_pin_oe_n[0] |-> !o_pin_pu[0])
    else $error("pull-up on while driving");
  od_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_pin_oe_n[PFSM_SDA_PIN] |-> !o_pin_out[PFSM_SDA_PIN])
    else $error("open drain pin drove high");
  iic_low_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_pin_oe_n[PFSM_SCL_PIN] |-> !o_pin_pu[PFSM_SCL_PIN])
    else $error("i2c pull-up on while low");
  rst_hiz_a: assert property (@(posedge i_ref_clk) i_rst |=> o_pin_oe_n == '1 &&
    o_pin_pu[0] == 1'b0)
    else $error("pins not hi-z after reset");
  hd_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_pin_hidrv & ~PFSM_HICUR_MASK) == 8'h00)
    else $error("high drive on a low-current pin");
  c_bg_c: cover property (@(posedge i_ref_clk) $rose(o_bg_mode));
  c_port_c: cover property (@(posedge i_ref_clk) $fell(st_r.opt_r[0]) && !i_rst);
  c_iic_c: cover property (@(posedge i_ref_clk) o_pin_pu[PFSM_SDA_PIN] && o_pin_oe_n[2]);
endmodule

//--- pfsm_pad_model.sv
`timescale 1ns/1ps
// pads plus debug host, as seen from the block's pin side
module pfsm_pad_model
  import pfsm_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe_n,
  input wire logic [7:0] i_pu,
  input wire logic i_host_low,     // host clamps the mode pin low
  output logic [7:0] o_lvl
);
  logic churn_r = 1'b0; // floating pads never hold a stale value
  //////////////////////////////////////////////////////////////
  // toggles every cycle so an undriven pad cannot pass by luck
  always_ff @(posedge i_ref_clk)
  begin
    churn_r <= ~churn_r;
  end
  // resolve each pad: driver, then host clamp then pull-up
  always_comb
  begin
    for (int g = 0; g < 8; g++)
    begin
      if (!i_oe_n[g])
        o_lvl[g] = i_out[g];
      else if (g == PFSM_DBG_PIN && i_host_low)
        o_lvl[g] = 1'b0;
      else if (i_pu[g])
        o_lvl[g] = 1'b1;
      else
        o_lvl[g] = churn_r ^ g[0];
    end
  end
endmodule

//--- tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pfsm_pkg::*;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, pin_lvl, o_rdata, o_pin_out, o_pin_oe_n;
  logic [7:0] o_pin_pu, o_pin_hidrv, o_per_in, r8;
  logic [31:0] i_alt_en = 32'h0, i_alt_out = 32'h0, i_alt_drv = 32'h0;
  logic i_dbg_tx_en = 1'b0, i_dbg_speedup = 1'b0, host_low = 1'b0;
  logic o_dbg_rx, o_bg_mode, o_rst_pin_out, o_rst_pin_oe_n;
  int n_mismatch = 0, total_checks = 0, seed = 24052;
  int dat, dir, pue, hdr; // bench copy of the port registers
  pfsm_top DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pin(pin_lvl), .i_alt_en(i_alt_en), .i_alt_out(i_alt_out),
    .i_alt_drv(i_alt_drv), .i_dbg_tx_en(i_dbg_tx_en),
    .i_dbg_speedup(i_dbg_speedup), .o_pin_out(o_pin_out),
    .o_pin_oe_n(o_pin_oe_n), .o_pin_pu(o_pin_pu), .o_pin_hidrv(o_pin_hidrv),
    .o_per_in(o_per_in), .o_dbg_rx(o_dbg_rx), .o_bg_mode(o_bg_mode),
    .o_rst_pin_out(o_rst_pin_out), .o_rst_pin_oe_n(o_rst_pin_oe_n));
  pfsm_pad_model pads (.i_ref_clk(i_ref_clk), .i_out(o_pin_out),
    .i_oe_n(o_pin_oe_n), .i_pu(o_pin_pu), .i_host_low(host_low),
    .o_lvl(pin_lvl));
  //////////////////////////////////////////////////////////////
  // 200 MHz bus clock
  initial
  begin
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t pad got %h exp %h", $time, got, exp);
    end
  endtask
  // read strobe one cycle, data stands the cycle after it only
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    total_checks++;
    if (o_rdata !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t read %h got %h exp %h", $time, a, o_rdata, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  // pads lag a write by two edges; three keeps clear of the launch
  task automatic settle;
    repeat (3) @(posedge i_ref_clk);
    #1;
  endtask
  task automatic do_reset;
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (16) @(posedge i_ref_clk);
    #1;
    chk({7'h0, o_rst_pin_oe_n}, 8'h00);
    chk(o_pin_oe_n, 8'hff);
    chk(o_pin_pu, 8'h10);
    chk(o_pin_hidrv, 8'h00);
    @(posedge i_ref_clk);
    i_rst <= 1'b0;
    settle();
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 10k cycles
  initial
  begin
    #300000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    do_reset();
    chk({6'h0, o_bg_mode, o_rst_pin_oe_n}, 8'h01);
    rd_chk(PFSM_A_OPT, PFSM_OPT_RST);
    // debug link: low drive, speedup pulse, release to pull-up
    i_dbg_tx_en <= 1'b1;
    settle();
    chk({5'h0, o_pin_out[4], o_pin_oe_n[4], o_dbg_rx}, 8'h00);
    i_dbg_tx_en <= 1'b0;
    i_dbg_speedup <= 1'b1;
    settle();
    chk({6'h0, o_pin_out[4], o_pin_oe_n[4]}, 8'h02);
    i_dbg_speedup <= 1'b0;
    settle();
    chk({6'h0, o_pin_oe_n[4], o_pin_pu[4]}, 8'h03);
    // mode bit is read only; unmapped space reads zero
    wr(PFSM_A_OPT, 8'h02);
    wr(4'h7, 8'hff);
    rd_chk(PFSM_A_OPT, 8'h00);
    rd_chk(4'h9, 8'h00);
    // random port settings against the bench model
    repeat (20)
    begin
      dat = $random(seed) & 255;
      dir = $random(seed) & 255;
      pue = $random(seed) & 255;
      hdr = $random(seed) & 255;
      wr(PFSM_A_DAT, dat[7:0]);
      wr(PFSM_A_DIR, dir[7:0]);
      wr(PFSM_A_PUE, pue[7:0]);
      wr(PFSM_A_HDR, hdr[7:0]);
      settle();
      r8 = ~((dir & 8'hf3) | (dir & ~dat & 8'h0c));
      chk(o_pin_oe_n, r8);
      chk(o_pin_out & ~r8, dat[7:0] & ~r8);
      chk(o_pin_pu, pue[7:0] & ~dir[7:0] & 8'hef);
      chk(o_pin_hidrv, hdr[7:0] & dir[7:0] & PFSM_HICUR_MASK);
      rd_chk(PFSM_A_DIR, dir[7:0]);
    end
    // stacked alternates on pins 1 and 5: highest enabled wins
    wr(PFSM_A_DIR, 8'h00);
    wr(PFSM_A_HDR, 8'h20);
    wr(PFSM_A_PUE, 8'h06);
    for (int k = 1; k <= 4; k++)
    begin
      r8 = $random(seed);
      i_alt_en <= {8'h0, 4'((1 << k) - 1), 12'h0, 4'((1 << k) - 1), 4'h0};
      i_alt_drv <= 32'h00f000f0;
      i_alt_out <= {8'h0, r8[7:4], 12'h0, r8[3:0], 4'h0};
      settle();
      chk(o_pin_oe_n & 8'h22, 8'h00);
      chk(o_pin_out & 8'h22, {2'h0, r8[k + 3], 3'h0, r8[k - 1], 1'h0});
      chk(o_pin_hidrv, 8'h20);
    end
    i_alt_drv <= 32'h0;
    settle();
    chk(o_pin_pu & 8'h22, 8'h02);
    chk(o_per_in & 8'hdf, 8'h02);
    // no interrupt flags live here; peripheral software clears its own
    i_alt_en <= 32'h0; // sharers off before the next enable
    // sda on alternate three in i2c mode keeps pull-up unless low
    wr(PFSM_A_OPT, 8'h04);
    for (int v = 0; v < 2; v++)
    begin
      i_alt_en <= 32'h400;
      i_alt_drv <= 32'h400;
      i_alt_out <= v ? 32'h400 : 32'h0;
      settle();
      chk({6'h0, o_pin_oe_n[2], o_pin_pu[2]}, v ? 8'h03 : 8'h00);
    end
    // host clamps the mode pin through reset: background mode
    host_low <= 1'b1;
    do_reset();
    host_low <= 1'b0;
    chk({7'h0, o_bg_mode}, 8'h01);
    rd_chk(PFSM_A_OPT, 8'h03);
    give_verdict();
  end
endmodule
